// ### shared/imdc_pkg.sv
package imdc_pkg;
    // register addresses in the special-function space
    localparam logic [15:0] ADDR_SLAVE = 16'hff80;
    localparam logic [15:0] ADDR_TX1 = 16'hff81;
    localparam logic [15:0] ADDR_TX2 = 16'hff82;
    localparam logic [15:0] ADDR_RX1 = 16'hff83;
    localparam logic [15:0] ADDR_RX2 = 16'hff84;
    localparam logic [15:0] ADDR_CSR = 16'hff85;
    localparam logic [15:0] ADDR_INT6 = 16'hff95;
    localparam logic [7:0] REG_RESET = 8'h00;

    // field positions
    localparam int CSR_LEN_BIT = 0;
    localparam int CSR_GO_BIT = 1;
    localparam int CSR_ERR_BIT = 2;
    localparam int INT6_FLAG_BIT = 2;
    localparam int INT6_EN_BIT = 3;
    localparam int ADDR_DIR_BIT = 0;

    // words queued toward the link: {two_byte, last_write, byte}
    localparam int FIFO_WIDTH = 10;
    localparam int FIFO_DEPTH = 32;
    localparam int WORD_TWO_BIT = 9;
    localparam int WORD_LAST_BIT = 8;

    // link timing: one link clock edge per quarter of an scl bit
    localparam int SCL_FREQ_KHZ = 400;
    localparam int PHASES_PER_BIT = 4;
    localparam int LINK_FREQ_KHZ = SCL_FREQ_KHZ * PHASES_PER_BIT;

    typedef enum logic [2:0] {
        LS_IDLE,
        LS_START,
        LS_BIT,
        LS_ACK,
        LS_WAIT,
        LS_STOP
    } imdc_link_state_t;
endpackage : imdc_pkg

// ### design/imdc_fifo.sv
`timescale 1ns/1ps
module imdc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    // output stage is a register, refilled whenever it empties or is taken
    assign in_ready = (count != FULL_COUNT);
    assign push = in_valid && in_ready;
    assign pop = (count != '0) && (!out_valid || out_ready);

    // storage array, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end

    // registered read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem[rd_ptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule : imdc_fifo

// ### design/imdc_top.sv
`timescale 1ns/1ps
module imdc_top #(
    parameter int FIFO_W = imdc_pkg::FIFO_WIDTH,
    parameter int FIFO_D = imdc_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic irq,
    output logic scl_out,
    output logic scl_oe,
    input wire logic scl_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic sda_in
);
    import imdc_pkg::*;

    // system-side registers
    logic [7:0] slave_address_register;
    logic [7:0] tx_byte_primary;
    logic [7:0] tx_byte_secondary;
    logic [7:0] rx_byte_primary;
    logic [7:0] rx_byte_secondary;
    logic two_byte_select;
    logic transfer_go_busy;
    logic ack_error_flag;
    logic transfer_done_flag;
    logic transfer_done_irq_enable;

    // loader and crossing toward the link
    logic ld_active;
    logic [1:0] ld_cnt;
    logic [FIFO_W-1:0] ld_word;
    logic ld_final;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [FIFO_W-1:0] fifo_out_data;
    logic [FIFO_W-1:0] xfer_word;
    logic req_tgl;
    logic pend;
    logic ack_meta, ack_sync, ack_prev;
    logic done_meta, done_sync, done_prev;
    logic wr_ok;
    logic launch;
    logic dir_read;

    // link-side state
    imdc_link_state_t lstate;
    logic [1:0] ph;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic tx_mode;
    logic hdr;
    logic is_read;
    logic two;
    logic rd_second;
    logic last_tx;
    logic nack;
    logic [7:0] lrx1;
    logic [7:0] lrx2;
    logic byte_avail;
    logic [FIFO_W-1:0] cur_word;
    logic ack_tgl;
    logic done_tgl;
    logic req_meta, req_sync, req_prev;
    logic scl_meta, scl_s;
    logic sda_meta, sda_s;
    logic more_rx;

    // data registers take writes only while idle, so a running frame keeps its bytes
    assign wr_ok = sfr_wr && !transfer_go_busy;
    assign launch = wr_ok && (sfr_addr == ADDR_CSR) && sfr_wdata[CSR_GO_BIT];
    assign dir_read = slave_address_register[ADDR_DIR_BIT];

    // software-owned registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_address_register <= REG_RESET;
            tx_byte_primary <= REG_RESET;
            tx_byte_secondary <= REG_RESET;
            two_byte_select <= 1'b0;
            transfer_done_irq_enable <= 1'b0;
        end else begin
            if (wr_ok && sfr_addr == ADDR_SLAVE) begin
                slave_address_register <= sfr_wdata;
            end
            if (wr_ok && sfr_addr == ADDR_TX1) begin
                tx_byte_primary <= sfr_wdata;
            end
            if (wr_ok && sfr_addr == ADDR_TX2) begin
                tx_byte_secondary <= sfr_wdata;
            end
            if (wr_ok && sfr_addr == ADDR_CSR) begin
                two_byte_select <= sfr_wdata[CSR_LEN_BIT];
            end
            // enable stays writable mid-frame; it only gates the line
            if (sfr_wr && sfr_addr == ADDR_INT6) begin
                transfer_done_irq_enable <= sfr_wdata[INT6_EN_BIT];
            end
        end
    end

    // busy, error and done flags; frame end from the link wins over any clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            transfer_go_busy <= 1'b0;
            ack_error_flag <= 1'b0;
            transfer_done_flag <= 1'b0;
            rx_byte_primary <= REG_RESET;
            rx_byte_secondary <= REG_RESET;
        end else begin
            if (launch) begin
                transfer_go_busy <= 1'b1;
                ack_error_flag <= 1'b0;
                transfer_done_flag <= 1'b0;
            end
            if (done_sync != done_prev) begin
                transfer_go_busy <= 1'b0;
                transfer_done_flag <= 1'b1;
                if (nack) begin
                    ack_error_flag <= 1'b1;
                end
                // link payload is quiet once the done toggle has crossed
                if (dir_read) begin
                    rx_byte_primary <= lrx1;
                    if (two_byte_select) begin
                        rx_byte_secondary <= lrx2;
                    end
                end
            end
        end
    end

    // interrupt line and read data, both registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            sfr_rdata <= REG_RESET;
        end else begin
            irq <= transfer_done_flag && transfer_done_irq_enable;
            if (sfr_rd) begin
                unique case (sfr_addr)
                    ADDR_SLAVE: sfr_rdata <= slave_address_register;
                    ADDR_TX1: sfr_rdata <= tx_byte_primary;
                    ADDR_TX2: sfr_rdata <= tx_byte_secondary;
                    ADDR_RX1: sfr_rdata <= rx_byte_primary;
                    ADDR_RX2: sfr_rdata <= rx_byte_secondary;
                    ADDR_CSR: sfr_rdata <= {5'h00, ack_error_flag, transfer_go_busy, two_byte_select};
                    ADDR_INT6: sfr_rdata <= {4'h0, transfer_done_irq_enable, transfer_done_flag, 2'h0};
                    default: sfr_rdata <= REG_RESET;
                endcase
            end
        end
    end

    // words of one frame: address, then the write bytes
    always_comb begin
        ld_word = '0;
        unique case (ld_cnt)
            2'd0: ld_word = {two_byte_select, 1'b0, slave_address_register};
            2'd1: ld_word = {1'b0, !two_byte_select, tx_byte_primary};
            default: ld_word = {1'b0, 1'b1, tx_byte_secondary};
        endcase
    end
    assign ld_final = (ld_cnt == 2'd0 && dir_read) || (ld_cnt == 2'd1 && !two_byte_select) || (ld_cnt == 2'd2);

    // loader stalls whenever the queue is full
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_active <= 1'b0;
            ld_cnt <= 2'd0;
        end else if (launch) begin
            ld_active <= 1'b1;
            ld_cnt <= 2'd0;
        end else if (ld_active && fifo_in_ready) begin
            if (ld_final) begin
                ld_active <= 1'b0;
            end else begin
                ld_cnt <= ld_cnt + 2'd1;
            end
        end
    end

    imdc_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(ld_active),
        .in_ready(fifo_in_ready),
        .in_data(ld_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // one word in flight at a time; the link's ack toggle frees the slot
    assign fifo_out_ready = !pend;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend <= 1'b0;
            req_tgl <= 1'b0;
            xfer_word <= '0;
        end else begin
            if (fifo_out_valid && !pend) begin
                xfer_word <= fifo_out_data;
                req_tgl <= !req_tgl;
                pend <= 1'b1;
            end else if (ack_sync != ack_prev) begin
                pend <= 1'b0;
            end
        end
    end

    // toggles coming back from the link domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            ack_prev <= 1'b0;
            done_meta <= 1'b0;
            done_sync <= 1'b0;
            done_prev <= 1'b0;
        end else begin
            ack_meta <= ack_tgl;
            ack_sync <= ack_meta;
            ack_prev <= ack_sync;
            done_meta <= done_tgl;
            done_sync <= done_meta;
            done_prev <= done_sync;
        end
    end

    // link-domain synchronisers for the request toggle and both bus lines
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_prev <= 1'b0;
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            req_meta <= req_tgl;
            req_sync <= req_meta;
            req_prev <= req_sync;
            scl_meta <= scl_in;
            scl_s <= scl_meta;
            sda_meta <= sda_in;
            sda_s <= sda_meta;
        end
    end

    // open-drain: the pin level driven is always low, oe decides
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    assign more_rx = two && !rd_second;

    // bit engine: four link edges per scl bit, phase 2 waits for scl to rise
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lstate <= LS_IDLE;
            ph <= 2'd0;
            sh <= 8'h00;
            bitn <= 3'd0;
            tx_mode <= 1'b1;
            hdr <= 1'b0;
            is_read <= 1'b0;
            two <= 1'b0;
            rd_second <= 1'b0;
            last_tx <= 1'b1;
            nack <= 1'b0;
            lrx1 <= 8'h00;
            lrx2 <= 8'h00;
            byte_avail <= 1'b0;
            cur_word <= '0;
            ack_tgl <= 1'b0;
            done_tgl <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            // word held stable by the system side until our ack crosses back
            if (req_sync != req_prev) begin
                byte_avail <= 1'b1;
                cur_word <= xfer_word;
            end
            if (!(ph == 2'd2 && !scl_s)) begin
                ph <= ph + 2'd1;
            end
            unique case (lstate)
                LS_IDLE: begin
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                    ph <= 2'd0;
                    if (byte_avail && !last_tx) begin
                        // drop words left from a refused write
                        last_tx <= cur_word[WORD_LAST_BIT];
                        byte_avail <= 1'b0;
                        ack_tgl <= !ack_tgl;
                    end else if (byte_avail) begin
                        sh <= cur_word[7:0];
                        is_read <= cur_word[ADDR_DIR_BIT];
                        last_tx <= cur_word[ADDR_DIR_BIT];
                        two <= cur_word[WORD_TWO_BIT];
                        byte_avail <= 1'b0;
                        ack_tgl <= !ack_tgl;
                        nack <= 1'b0;
                        rd_second <= 1'b0;
                        hdr <= 1'b1;
                        tx_mode <= 1'b1;
                        lstate <= LS_START;
                    end
                end
                LS_START: begin
                    if (ph == 2'd0) begin
                        sda_oe <= 1'b1;
                    end else if (ph == 2'd3) begin
                        scl_oe <= 1'b1;
                        bitn <= 3'd7;
                        lstate <= LS_BIT;
                    end
                end
                LS_BIT: begin
                    unique case (ph)
                        2'd0: sda_oe <= tx_mode ? !sh[7] : 1'b0;
                        2'd1: scl_oe <= 1'b0;
                        2'd2: begin
                            if (scl_s && !tx_mode) begin
                                sh <= {sh[6:0], sda_s};
                            end
                        end
                        default: begin
                            scl_oe <= 1'b1;
                            if (tx_mode) begin
                                sh <= {sh[6:0], 1'b0};
                            end
                            if (bitn == 3'd0) begin
                                lstate <= LS_ACK;
                            end else begin
                                bitn <= bitn - 3'd1;
                            end
                        end
                    endcase
                end
                LS_ACK: begin
                    unique case (ph)
                        2'd0: sda_oe <= tx_mode ? 1'b0 : more_rx;
                        2'd1: scl_oe <= 1'b0;
                        2'd2: begin
                            if (scl_s && tx_mode && sda_s) begin
                                nack <= 1'b1;
                            end
                            if (scl_s && !tx_mode && !rd_second) begin
                                lrx1 <= sh;
                            end
                            if (scl_s && !tx_mode && rd_second) begin
                                lrx2 <= sh;
                            end
                        end
                        default: begin
                            scl_oe <= 1'b1;
                            bitn <= 3'd7;
                            // a refused byte ends the frame at once
                            if (tx_mode && nack) begin
                                lstate <= LS_STOP;
                            end else if (tx_mode && hdr && is_read) begin
                                tx_mode <= 1'b0;
                                hdr <= 1'b0;
                                lstate <= LS_BIT;
                            end else if (tx_mode && (hdr || !last_tx)) begin
                                hdr <= 1'b0;
                                lstate <= LS_WAIT;
                            end else if (!tx_mode && more_rx) begin
                                rd_second <= 1'b1;
                                lstate <= LS_BIT;
                            end else begin
                                lstate <= LS_STOP;
                            end
                        end
                    endcase
                end
                LS_WAIT: begin
                    // scl held low until the next byte arrives
                    ph <= 2'd0;
                    if (byte_avail) begin
                        sh <= cur_word[7:0];
                        last_tx <= cur_word[WORD_LAST_BIT];
                        byte_avail <= 1'b0;
                        ack_tgl <= !ack_tgl;
                        tx_mode <= 1'b1;
                        lstate <= LS_BIT;
                    end
                end
                LS_STOP: begin
                    unique case (ph)
                        2'd0: sda_oe <= 1'b1;
                        2'd1: scl_oe <= 1'b0;
                        2'd2: sda_oe <= 1'b1;
                        default: begin
                            sda_oe <= 1'b0;
                            done_tgl <= !done_tgl;
                            lstate <= LS_IDLE;
                        end
                    endcase
                end
                default: lstate <= LS_IDLE;
            endcase
        end
    end
endmodule : imdc_top

// ### tb/imdc_monitor.sv
`timescale 1ns/1ps
module imdc_monitor #(
    parameter int FIFO_W = 10,
    parameter int FIFO_D = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic irq,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic sda_in
);
    import imdc_pkg::*;
    logic rd_csr, rd_int6, mapped, go_wr;
    // decode of the accesses the properties key on
    assign rd_csr = sfr_rd && sfr_addr == ADDR_CSR;
    assign rd_int6 = sfr_rd && sfr_addr == ADDR_INT6;
    assign go_wr = sfr_wr && sfr_addr == ADDR_CSR && sfr_wdata[CSR_GO_BIT];
    assign mapped = (sfr_addr >= ADDR_SLAVE && sfr_addr <= ADDR_CSR) || sfr_addr == ADDR_INT6;

    rdata_hold_a:
        assert property (@(posedge clk) disable iff (!rst_n) !$past(sfr_rd) |-> $stable(sfr_rdata))
        else $error("read data moved without a read");
    unmapped_zero_a:
        assert property (@(posedge clk) disable iff (!rst_n) sfr_rd && !mapped |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    csr_unused_a:
        assert property (@(posedge clk) disable iff (!rst_n) rd_csr |=> sfr_rdata[7:3] == 5'h00)
        else $error("unused status bits set");
    int6_unused_a:
        assert property (@(posedge clk) disable iff (!rst_n) rd_int6 |=> sfr_rdata[7:4] == 4'h0 && sfr_rdata[1:0] == 2'h0)
        else $error("unused interrupt bits set");
    irq_follows_a:
        assert property (@(posedge clk) disable iff (!rst_n) rd_int6 ##1 (sfr_rdata[3] && sfr_rdata[2]) |-> ##[0:2] irq)
        else $error("irq missing with flag and enable");
    go_busy_a:
        assert property (@(posedge clk) disable iff (!rst_n) go_wr ##1 rd_csr |=> sfr_rdata[2:1] == 2'b01)
        else $error("busy not set or error not cleared at start");
    irq_clear_a:
        assert property (@(posedge clk) disable iff (!rst_n) go_wr |-> ##[1:3] !irq)
        else $error("irq not cleared by start");
    start_form_a:
        assert property (@(posedge link_clk) disable iff (!rst_n) $rose(sda_oe) && !scl_oe |-> ##[1:4] scl_oe)
        else $error("start not followed by clock low");
    stop_idle_a:
        assert property (@(posedge link_clk) disable iff (!rst_n) $fell(sda_oe) && !scl_oe |=> !scl_oe && !sda_oe)
        else $error("bus not idle after stop");
    open_drain_a:
        assert property (@(posedge link_clk) disable iff (!rst_n) !scl_out && !sda_out)
        else $error("open drain level not low");

    // main scenarios reached
    cover property (@(posedge clk) disable iff (!rst_n) go_wr);
    cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
    cover property (@(posedge link_clk) disable iff (!rst_n) $rose(sda_oe) && !scl_oe);
endmodule : imdc_monitor

bind imdc_top imdc_monitor #(.FIFO_W(FIFO_W), .FIFO_D(FIFO_D)) u_mon (.clk(clk), .rst_n(rst_n),
    .link_clk(link_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .irq(irq), .scl_out(scl_out), .scl_oe(scl_oe), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .sda_in(sda_in));

// ### tb/imdc_slave_model.sv
`timescale 1ns/1ps
module imdc_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic [6:0] my_addr,
    input wire logic nack_data,
    input wire logic stretch,
    input wire logic [7:0] rd0,
    input wire logic [7:0] rd1,
    output logic sda_low,
    output logic scl_low
);
    logic [7:0] wr_q[$];
    logic mack_q[$];
    logic [7:0] b;
    logic st, m;

    // a rising sda while scl is high is a stop and ends the byte early
    task automatic get_byte();
        st = 0;
        for (int i = 7; i >= 0; i--) begin
            @(posedge scl);
            b[i] = sda;
            @(negedge scl or posedge sda);
            if (scl) begin
                st = 1;
                return;
            end
        end
    endtask : get_byte

    // ack slot, optionally stretching the clock low for a while
    task automatic ack_slot(input logic ok);
        #10 sda_low = ok;
        if (stretch) begin
            scl_low = 1;
            #200 scl_low = 0;
        end
        @(posedge scl);
        @(negedge scl);
        #10 sda_low = 0;
    endtask : ack_slot

    // data changes only while scl is low; master ack sampled on the ninth clock
    task automatic put_byte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            #10 sda_low = !d[i];
            @(posedge scl);
            @(negedge scl);
        end
        #10 sda_low = 0;
        @(posedge scl);
        m = sda;
        mack_q.push_back(m);
        if (!m) @(negedge scl);
    endtask : put_byte

    initial begin
        sda_low = 0;
        scl_low = 0;
        forever begin
            @(negedge sda iff scl === 1'b1);
            get_byte();
            if (st) continue;
            ack_slot(b[7:1] == my_addr);
            if (b[7:1] != my_addr) continue;
            if (b[0]) begin
                put_byte(rd0);
                if (!m) put_byte(rd1);
            end else begin
                get_byte();
                while (!st) begin
                    wr_q.push_back(b);
                    ack_slot(!nack_data);
                    get_byte();
                end
            end
        end
    end
endmodule : imdc_slave_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import imdc_pkg::*;
    logic clk = 0, link_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0;
    logic [15:0] sfr_addr = 16'h0000;
    logic [7:0] sfr_wdata = 8'h00, sfr_rdata, rd0, rd1, m_rx1 = 8'h00, m_rx2 = 8'h00;
    logic irq, scl_out, scl_oe, sda_out, sda_oe, s_sda_low, s_scl_low, scl, sda;
    logic [6:0] s_addr = 7'h00;
    logic nack_data = 0, stretch = 0;
    int n_errors = 0, checks = 0, cyc = 0;

    always #2.5 clk = ~clk;
    initial begin
        #3;
        forever #15 link_clk = ~link_clk;
    end
    // open-drain wires with pull-ups
    assign scl = !(scl_oe || s_scl_low);
    assign sda = !(sda_oe || s_sda_low);

    imdc_top dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq(irq), .scl_out(scl_out),
        .scl_oe(scl_oe), .scl_in(scl), .sda_out(sda_out), .sda_oe(sda_oe), .sda_in(sda));
    imdc_slave_model slave (.scl(scl), .sda(sda), .my_addr(s_addr), .nack_data(nack_data),
        .stretch(stretch), .rd0(rd0), .rd1(rd1), .sda_low(s_sda_low), .scl_low(s_scl_low));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask : rd

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // hang guard, well above ten frames with stretching
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // one frame: program, start with a status read straight after, wait, then compare
    task automatic frame(input bit dir, input bit len, input bit hit, input bit ien);
        logic [7:0] t1, t2, v;
        int n, ew;
        t1 = 8'($urandom);
        t2 = 8'($urandom);
        rd0 = 8'($urandom);
        rd1 = 8'($urandom);
        s_addr = 7'($urandom);
        wr(ADDR_INT6, ien ? 8'hff : 8'hf7);
        wr(ADDR_SLAVE, {hit ? s_addr : ~s_addr, dir});
        wr(ADDR_TX1, t1);
        wr(ADDR_TX2, t2);
        wr(ADDR_RX1, 8'ha5);
        slave.wr_q.delete();
        slave.mack_q.delete();
        @(posedge clk);
        sfr_addr <= ADDR_CSR;
        sfr_wdata <= {6'h3e, 1'b1, len};
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 chk("busy", {7'h01, len}, sfr_rdata);
        n = 0;
        v = 8'h02;
        while (v[1] && n < 3000) begin
            rd(ADDR_CSR, v);
            n++;
        end
        chk("csr", {5'h00, !hit || (!dir && nack_data), 1'b0, len}, v);
        rd(ADDR_INT6, v);
        chk("int6", {4'h0, ien, 3'h4}, v);
        chk("irq", {7'h00, ien}, {7'h00, irq});
        if (dir && hit) begin
            m_rx1 = rd0;
            if (len) m_rx2 = rd1;
            chk("mack count", 8'(1 + len), 8'(slave.mack_q.size()));
            chk("last mack", 8'h01, {7'h00, slave.mack_q[len]});
        end
        rd(ADDR_RX1, v);
        chk("rx1", m_rx1, v);
        rd(ADDR_RX2, v);
        chk("rx2", m_rx2, v);
        ew = (!dir && hit) ? (nack_data ? 1 : 1 + len) : 0;
        chk("wr count", 8'(ew), 8'(slave.wr_q.size()));
        if (ew > 0) chk("tx1", t1, slave.wr_q[0]);
        if (ew > 1) chk("tx2", t2, slave.wr_q[1]);
    endtask : frame

    initial begin
        logic [7:0] v;
        void'($urandom(32'h28a7));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // reset values of every register and one unmapped place
        for (int a = 0; a < 8; a++) begin
            rd(a == 6 ? ADDR_INT6 : a == 7 ? 16'hff86 : ADDR_SLAVE + 16'(a), v);
            chk("reset", 8'h00, v);
        end
        // all direction and length mixes, one address miss, one data nack
        for (int i = 0; i < 10; i++) begin
            nack_data = (i == 6);
            stretch = 1'($urandom);
            frame(i[0], i[1], i != 5, i != 3);
        end
        tally_and_finish();
    end
endmodule : tb
